// ===== src/civ_top.sv
// Purpose: core-side interrupt and reset vectoring with stack pointer
// Assumes: sequencer and sources run on pclk; APB register access
// Notes:   source 0 is external_request_zero
//
// Function
// (RULE1) core clock is pclk itself, never divided inside.
// (RULE2) one instruction may retire every clock cycle.
// (RULE3) two-operand alu op reads, computes and writes back in one cycle.
// (RULE4) reset and every source own a distinct vector address.
// (RULE5) a source is taken only if its enable and global enable are set.
// (RULE6) reset and interrupt vectors sit at the lowest program addresses.
// (RULE7) among pending requests the lowest vector address is served first.
// (RULE8) reset outranks everything; external_request_zero comes next.
// (RULE9) accepting an interrupt clears the global enable.
// (RULE10) software may set global enable in a handler to allow nesting.
// (RULE11) return_from_handler sets the global enable again.
// (RULE12) taking a flag source vectors and clears that flag in hardware.
// (RULE13) writing one to a flag clears it; writing zero leaves it.
// (RULE14) 16-bit stack pointer in two bytes, reset to top_of_data_memory.
// (RULE15) flags set while disabled stay pending until served or cleared.
// (RULE16) level sources request only while their condition is present.
// (RULE17) after a return one main instruction retires before any service.
// (RULE18) entry takes four cycles, pushing the program counter first.
// (RULE19) simultaneous requests resolve same cycle; only winner acknowledged.
//
// Design decisions made here: the APB slave port and the register addresses.

`timescale 1ns/1ps

module civ_top
	import civ_pkg::*;
#(
	parameter int          NSRC       = 8,
	parameter logic [31:0] LEVEL_MASK = 32'h0000_0000,
	parameter logic [15:0] TOP_OF_MEM = CIV_TOP_OF_DATA_MEMORY
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// interrupt sources
	input  wire logic [NSRC-1:0]   src_req,
	output logic [NSRC-1:0]        src_ack,
	// instruction sequencer
	input  wire logic              instr_done,
	input  wire logic              return_from_handler,
	input  wire logic [15:0]       pc_now,
	output logic                   vector_valid,
	output logic [15:0]            vector_addr,
	// stack write port
	output logic                   push_we,
	output logic [15:0]            push_addr,
	output logic [7:0]             push_data,
	// alu
	input  wire logic              alu_go,
	input  wire logic [2:0]        alu_op,
	input  wire logic [4:0]        alu_dst,
	input  wire logic [7:0]        alu_a,
	input  wire logic [7:0]        alu_b,
	output logic                   alu_valid,
	output logic [4:0]             alu_wb_dst,
	output logic [7:0]             alu_result,
	// interrupt to host
	output logic                   irq
);

	localparam int IW = $clog2(NSRC + 1);

	// ****************************************
	// elaboration check
	// ****************************************
	if (NSRC < 1 || NSRC > 31) begin : g_bad_nsrc
		$error("civ_top: NSRC must lie between 1 and 31");
	end

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [31:0] widen(input logic [NSRC-1:0] v);
		logic [31:0] w;
		w = CIV_ZERO_WORD;
		w[NSRC-1:0] = v;
		return w;
	endfunction

	function automatic logic [15:0] vector_of(input logic [IW-1:0] idx);
		// slot 0 is reset, sources follow upward
		return 16'((16'(idx) + 16'h0001) * CIV_VECTOR_STRIDE);
	endfunction

	function automatic logic [7:0] alu_calc(input logic [2:0] op,
	                                       input logic [7:0] a,
	                                       input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		unique case (op)
			CIV_ALU_ADD: r = 8'(a + b);
			CIV_ALU_SUB: r = 8'(a - b);
			CIV_ALU_AND: r = a & b;
			CIV_ALU_OR:  r = a | b;
			CIV_ALU_XOR: r = a ^ b;
			CIV_ALU_MOV: r = b;
			default:     r = 8'h00;
		endcase
		return r;
	endfunction

	// ****************************************
	// state
	// ****************************************
	civ_state_e        state;
	civ_state_e        next_state;
	logic [15:0]       sp;
	logic              gie;
	logic              hold;
	logic              reset_pending;
	logic [NSRC-1:0]   flags;
	logic [NSRC-1:0]   enable;
	logic [NSRC-1:0]   win_hold;
	logic [IW-1:0]     win_idx;
	logic [15:0]       pc_saved;
	logic [15:0]       last_vector;
	logic [CIV_EV_W-1:0] int_status;
	logic [CIV_EV_W-1:0] int_mask;

	// ****************************************
	// apb decode
	// ****************************************
	wire logic       apb_wr     = psel & penable & pready & pwrite;
	wire logic       apb_setup  = psel & ~penable;
	wire logic       hit_spl    = paddr == CIV_OFF_SP_LOW;
	wire logic       hit_sph    = paddr == CIV_OFF_SP_HIGH;
	wire logic       hit_ctrl   = paddr == CIV_OFF_CONTROL;
	wire logic       hit_en     = paddr == CIV_OFF_ENABLE;
	wire logic       hit_flags  = paddr == CIV_OFF_FLAGS;
	wire logic       hit_level  = paddr == CIV_OFF_LEVEL;
	wire logic       hit_ists   = paddr == CIV_OFF_INT_STATUS;
	wire logic       hit_imask  = paddr == CIV_OFF_INT_MASK;
	wire logic       hit_lvec   = paddr == CIV_OFF_LAST_VECTOR;
	wire logic       hit_any    = hit_spl | hit_sph | hit_ctrl | hit_en | hit_flags |
	                              hit_level | hit_ists | hit_imask | hit_lvec;
	wire logic       bad_access = psel & penable & pready & ~hit_any;

	// ****************************************
	// request gathering and priority
	// ****************************************
	wire logic [NSRC-1:0] level_sel  = LEVEL_MASK[NSRC-1:0];
	wire logic [NSRC-1:0] level_now  = src_req & level_sel;            // [RULE16]
	wire logic [NSRC-1:0] flag_set   = src_req & ~level_sel;
	wire logic [NSRC-1:0] pending    = (flags | level_now) & enable;   // [RULE15]
	wire logic [NSRC-1:0] eligible   = pending & {NSRC{gie}};          // [RULE5]
	wire logic            prio_any;
	wire logic [NSRC-1:0] prio_hot;
	wire logic [IW-1:0]   prio_idx;

	civ_prio #(
		.NSRC (NSRC)
	) u_prio (
		.req    (eligible),
		.any    (prio_any),
		.onehot (prio_hot),
		.index  (prio_idx)
	);

	// retiring instruction is the only legal entry point
	wire logic take = (state == CIV_IDLE) & ~reset_pending & instr_done &
	                  ~hold & prio_any;                                // [RULE17]

	// ****************************************
	// flag update: set beats both clears
	// ****************************************
	wire logic [NSRC-1:0] sw_clear = (apb_wr & hit_flags) ? pwdata[NSRC-1:0] : '0; // [RULE13]
	wire logic [NSRC-1:0] hw_clear = take ? (prio_hot & ~level_sel) : '0;        // [RULE12]
	wire logic [NSRC-1:0] next_flags = (flags & ~sw_clear & ~hw_clear) | flag_set;

	// ****************************************
	// interrupt status
	// ****************************************
	wire logic [CIV_EV_W-1:0] events = {bad_access, return_from_handler, take};
	wire logic [CIV_EV_W-1:0] ist_clr = (apb_wr & hit_ists) ? pwdata[CIV_EV_W-1:0] : '0;
	wire logic [CIV_EV_W-1:0] next_int_status = (int_status & ~ist_clr) | events;

	// ****************************************
	// read mux
	// ****************************************
	wire logic [31:0] ctrl_word = {29'h0000_0000, hold, state != CIV_IDLE, gie};
	wire logic [31:0] rd_word =
		hit_spl   ? {24'h00_0000, sp[7:0]}        :
		hit_sph   ? {24'h00_0000, sp[15:8]}       :
		hit_ctrl  ? ctrl_word                     :
		hit_en    ? widen(enable)                 :
		hit_flags ? widen(flags)                  :
		hit_level ? widen(level_now)              :
		hit_ists  ? {29'h0000_0000, int_status}   :
		hit_imask ? {29'h0000_0000, int_mask}     :
		hit_lvec  ? {16'h0000, last_vector}       : CIV_ZERO_WORD;

	// ****************************************
	// entry sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			CIV_IDLE:      if (take) next_state = CIV_ACCEPT;  // [RULE19]
			CIV_ACCEPT:    next_state = CIV_PUSH_LOW;          // [RULE18]
			CIV_PUSH_LOW:  next_state = CIV_PUSH_HIGH;
			CIV_PUSH_HIGH: next_state = CIV_VECTOR;
			CIV_VECTOR:    next_state = CIV_IDLE;
		endcase
	end

	wire logic        pushing   = (state == CIV_PUSH_LOW) | (state == CIV_PUSH_HIGH);
	wire logic        sp_sw_lo  = apb_wr & hit_spl;
	wire logic        sp_sw_hi  = apb_wr & hit_sph;
	// hardware stack motion overrides a software write in the same cycle
	wire logic [15:0] sp_sw     = {sp_sw_hi ? pwdata[7:0] : sp[15:8],
	                               sp_sw_lo ? pwdata[7:0] : sp[7:0]};
	wire logic [15:0] next_sp   = pushing             ? 16'(sp - 16'h0001) :
	                              return_from_handler ? 16'(sp + CIV_RETURN_POP) :
	                              sp_sw;                               // [RULE14]

	// global enable: software write, then entry clear, then return set
	wire logic gie_sw   = (apb_wr & hit_ctrl) ? pwdata[CIV_CTRL_GIE] : gie; // [RULE10]
	wire logic next_gie = return_from_handler ? 1'b1 :                     // [RULE11]
	                      take                ? 1'b0 : gie_sw;            // [RULE9]

	// ****************************************
	// apb and control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= CIV_ZERO_WORD;
		end else begin
			// no wait states: answer is prepared during setup
			pready  <= apb_setup;
			pslverr <= apb_setup & ~hit_any;
			prdata  <= (apb_setup & ~pwrite) ? rd_word : CIV_ZERO_WORD;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable     <= '0;
			int_mask   <= '0;
			int_status <= '0;
			irq        <= 1'b0;
		end else begin
			if (apb_wr & hit_en)
				enable <= pwdata[NSRC-1:0];
			if (apb_wr & hit_imask)
				int_mask <= pwdata[CIV_EV_W-1:0];
			int_status <= next_int_status;
			irq        <= |(next_int_status & int_mask);
		end
	end

	// ****************************************
	// core state, all on the undivided clock
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin // [RULE1]
		if (!presetn) begin
			state         <= CIV_IDLE;
			sp            <= TOP_OF_MEM;                 // [RULE14]
			gie           <= 1'b0;
			hold          <= 1'b0;
			reset_pending <= 1'b1;
			flags         <= '0;
		end else begin
			state <= next_state;
			sp    <= next_sp;
			gie   <= next_gie;
			flags <= next_flags;
			if (return_from_handler)
				hold <= 1'b1;
			else if (instr_done)
				hold <= 1'b0;                        // [RULE17]
			if (state == CIV_IDLE)
				reset_pending <= 1'b0;
		end
	end

	// ****************************************
	// winner capture and outputs to sequencer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_hold     <= '0;
			win_idx      <= '0;
			pc_saved     <= 16'h0000;
			src_ack      <= '0;
			last_vector  <= CIV_RESET_VECTOR;
			vector_valid <= 1'b0;
			vector_addr  <= CIV_RESET_VECTOR;
		end else begin
			src_ack      <= take ? prio_hot : '0;         // [RULE19]
			vector_valid <= 1'b0;
			if (take) begin
				win_hold <= prio_hot;
				win_idx  <= prio_idx;                     // [RULE7]
				pc_saved <= pc_now;
			end
			if (state == CIV_IDLE && reset_pending) begin
				vector_valid <= 1'b1;                     // [RULE8]
				vector_addr  <= CIV_RESET_VECTOR;         // [RULE6]
			end else if (state == CIV_VECTOR) begin
				vector_valid <= 1'b1;
				vector_addr  <= vector_of(win_idx);       // [RULE4]
				last_vector  <= vector_of(win_idx);
			end
		end
	end

	// ****************************************
	// stack push port
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			push_we   <= 1'b0;
			push_addr <= 16'h0000;
			push_data <= 8'h00;
		end else begin
			push_we   <= pushing;                         // [RULE18]
			push_addr <= sp;
			push_data <= (state == CIV_PUSH_LOW) ? pc_saved[7:0] : pc_saved[15:8];
		end
	end

	// ****************************************
	// single-cycle alu with write-back index
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alu_valid  <= 1'b0;
			alu_wb_dst <= 5'h00;
			alu_result <= 8'h00;
		end else begin
			// a new op is accepted every edge, overlapping the next fetch
			alu_valid  <= alu_go;                         // [RULE2]
			alu_wb_dst <= alu_dst;
			alu_result <= alu_calc(alu_op, alu_a, alu_b); // [RULE3]
		end
	end

endmodule

// ===== src/civ_pkg.sv
// Purpose: shared constants for the core interrupt vectoring block
// Assumes: APB register map, one aligned 32-bit word per register
// Notes:   offsets are byte addresses

package civ_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] CIV_OFF_SP_LOW      = 8'h00;
	localparam logic [7:0] CIV_OFF_SP_HIGH     = 8'h04;
	localparam logic [7:0] CIV_OFF_CONTROL     = 8'h08;
	localparam logic [7:0] CIV_OFF_ENABLE      = 8'h0c;
	localparam logic [7:0] CIV_OFF_FLAGS       = 8'h10;
	localparam logic [7:0] CIV_OFF_LEVEL       = 8'h14;
	localparam logic [7:0] CIV_OFF_INT_STATUS  = 8'h18;
	localparam logic [7:0] CIV_OFF_INT_MASK    = 8'h1c;
	localparam logic [7:0] CIV_OFF_LAST_VECTOR = 8'h20;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CIV_CTRL_GIE      = 0;
	localparam int CIV_CTRL_BUSY     = 1;
	localparam int CIV_CTRL_HOLD     = 2;
	localparam int CIV_EV_ENTRY      = 0;
	localparam int CIV_EV_RETURN     = 1;
	localparam int CIV_EV_BAD_ADDR   = 2;
	localparam int CIV_EV_W          = 3;

	// ****************************************
	// reset values and counts
	// ****************************************
	localparam logic [15:0] CIV_TOP_OF_DATA_MEMORY = 16'h025f;
	localparam logic [15:0] CIV_RESET_VECTOR       = 16'h0000;
	localparam logic [15:0] CIV_VECTOR_STRIDE      = 16'h0001;
	localparam logic [15:0] CIV_RETURN_POP         = 16'h0002;
	localparam int          CIV_ENTRY_CYCLES       = 4;
	localparam logic [31:0] CIV_ZERO_WORD          = 32'h0000_0000;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		CIV_ALU_ADD,
		CIV_ALU_SUB,
		CIV_ALU_AND,
		CIV_ALU_OR,
		CIV_ALU_XOR,
		CIV_ALU_MOV
	} civ_alu_e;

	typedef enum logic [2:0] {
		CIV_IDLE,
		CIV_ACCEPT,
		CIV_PUSH_LOW,
		CIV_PUSH_HIGH,
		CIV_VECTOR
	} civ_state_e;

endpackage

// ===== src/civ_prio.sv
// Purpose: fixed-priority picker, lowest index wins
// Assumes: requests already gated by enables
// Notes:   purely combinational

`timescale 1ns/1ps

module civ_prio #(
	parameter int NSRC = 8
) (
	// requests
	input  wire logic [NSRC-1:0]         req,
	// winner
	output logic                         any,
	output logic [NSRC-1:0]              onehot,
	output logic [$clog2(NSRC+1)-1:0]    index
);

	// ****************************************
	// scan from high to low so the lowest index is left standing
	// ****************************************
	always_comb begin
		any    = 1'b0;
		onehot = '0;
		index  = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				any    = 1'b1;
				onehot = '0;
				onehot[i] = 1'b1;
				index  = i[$clog2(NSRC+1)-1:0];
			end
		end
	end

endmodule

// ===== tb/civ_chk_sva.sv
// Purpose: port-level assertions for civ_top
// Assumes: bound to civ_top from the bench top file
// Notes:   entry timing checked with small windows

`timescale 1ns/1ps

module civ_chk #(
	parameter int NSRC = 8
) (
	// clock and reset
	input wire logic            pclk,
	input wire logic            presetn,
	// sources and sequencer
	input wire logic [NSRC-1:0] src_ack,
	input wire logic            return_from_handler,
	input wire logic            vector_valid,
	input wire logic [15:0]     vector_addr,
	input wire logic            push_we,
	input wire logic [15:0]     push_addr,
	// alu
	input wire logic            alu_go,
	input wire logic [2:0]      alu_op,
	input wire logic [4:0]      alu_dst,
	input wire logic [7:0]      alu_a,
	input wire logic [7:0]      alu_b,
	input wire logic            alu_valid,
	input wire logic [4:0]      alu_wb_dst,
	input wire logic [7:0]      alu_result
);
	logic [3:0] ack_idx;
	logic [3:0] last_idx;

	always_comb begin
		ack_idx = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--)
			if (src_ack[i])
				ack_idx = 4'(i);
	end

	// remembers the winner until its vector is issued
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_idx <= 4'h0;
		else if (|src_ack)
			last_idx <= ack_idx;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ack_onehot_a: assert property (
		|src_ack |-> $onehot(src_ack)) else $error("ack not one-hot");
	entry_seq_a: assert property (
		|src_ack |-> ##[1:3] push_we ##1 push_we ##[1:2] vector_valid)
		else $error("entry sequence broken");
	vec_addr_a: assert property (
		vector_valid && vector_addr != 16'h0 |-> vector_addr == 16'(last_idx) + 16'h1)
		else $error("vector does not match winner");
	push_order_a: assert property (
		push_we && !$past(push_we) |=> push_we && push_addr == $past(push_addr) - 16'h1)
		else $error("second push not one below");
	one_entry_a: assert property (
		|src_ack |=> !(|src_ack) [*4]) else $error("entry during entry");
	ret_gap_a: assert property (
		return_from_handler |=> !(|src_ack)) else $error("entry right after return");
	alu_wb_a: assert property (
		alu_go |=> alu_valid && alu_wb_dst == $past(alu_dst)) else $error("alu late");
	alu_add_a: assert property (
		alu_go && alu_op == 3'h0 |=> alu_result == $past(alu_a) + $past(alu_b))
		else $error("alu add wrong");
endmodule

// ===== tb/civ_seq_model.sv
// Purpose: instruction sequencer stand-in
// Assumes: one instruction retires each cycle once running, except in the return cycle
// Notes:   return pulse only on bench command

`timescale 1ns/1ps

module civ_seq_model (
	// clock and reset
	input wire logic   pclk,
	input wire logic   presetn,
	// bench command
	input wire logic   ret_cmd,
	// sequencer side
	input wire logic   vector_valid,
	output logic       instr_done,
	output logic       return_from_handler,
	output logic [15:0] pc_now
);
	logic seen;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= 1'b0;
			pc_now <= 16'h0100;
			return_from_handler <= 1'b0;
		end else begin
			if (vector_valid)
				seen <= 1'b1;
			pc_now <= pc_now + 16'h1;
			return_from_handler <= ret_cmd;
		end
	end

	// no retire in the return cycle itself
	assign instr_done = seen && !return_from_handler;
endmodule

// ===== tb/civ_top_tb.sv
// Purpose: self-checking bench for civ_top
// Assumes: source 6 is level-type, all others flag-type
// Notes:   vectors and alu results checked from queues

`timescale 1ns/1ps

module civ_top_tb;
	import civ_pkg::*;
	localparam logic [15:0] TOP = CIV_TOP_OF_DATA_MEMORY;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0, src_req = 8'h0, src_ack, alu_a = 8'h0, alu_b = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, irq, ret_cmd = 1'b0, instr_done, return_from_handler;
	logic vector_valid, push_we, alu_go = 1'b0, alu_valid;
	logic [15:0] pc_now, vector_addr, push_addr, ev;
	logic [7:0] push_data, alu_result;
	logic [2:0] alu_op = 3'h0;
	logic [4:0] alu_dst = 5'h0, alu_wb_dst;
	logic [12:0] ea;
	logic [15:0] exp_vec[$];
	logic [12:0] exp_alu[$];
	logic [7:0] ep;
	logic [7:0] exp_push[$];
	int err_total = 0, n_compared = 0, cyc = 0;

	civ_top #(.LEVEL_MASK(32'h0000_0040)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_req(src_req), .src_ack(src_ack),
		.instr_done(instr_done), .return_from_handler(return_from_handler),
		.pc_now(pc_now), .vector_valid(vector_valid), .vector_addr(vector_addr),
		.push_we(push_we), .push_addr(push_addr), .push_data(push_data),
		.alu_go(alu_go), .alu_op(alu_op), .alu_dst(alu_dst), .alu_a(alu_a),
		.alu_b(alu_b), .alu_valid(alu_valid), .alu_wb_dst(alu_wb_dst),
		.alu_result(alu_result), .irq(irq));
	civ_seq_model i_seq (.pclk(pclk), .presetn(presetn), .ret_cmd(ret_cmd),
		.vector_valid(vector_valid), .instr_done(instr_done),
		.return_from_handler(return_from_handler), .pc_now(pc_now));

	always #2 pclk = ~pclk;

	// ****************************************
	// tasks
	// ****************************************
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// starts one edge later so release and next setup never share a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			cmp(32'h1, 32'h0);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask

	task automatic src(input logic [7:0] m);
		@(posedge pclk);
		src_req <= m;
		@(posedge pclk);
		src_req <= 8'h0;
	endtask

	task automatic drain;
		for (int n = 0; n < 100 && exp_vec.size() + exp_alu.size() + exp_push.size() != 0; n++)
			@(posedge pclk);
	endtask

	function automatic logic [7:0] ref_alu(input logic [2:0] o, input logic [7:0] x, y);
		case (o)
			3'h0: return x + y;
			3'h1: return x - y;
			3'h2: return x & y;
			3'h3: return x | y;
			3'h4: return x ^ y;
			3'h5: return y;
			default: return 8'h0;
		endcase
	endfunction

	// ****************************************
	// output watcher
	// ****************************************
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			$display("[FAIL] %0t timeout", $time);
			final_report();
		end
	end

	// pc_now has already advanced once since the acceptance cycle
	always @(posedge pclk) begin
		if (presetn && |src_ack) begin
			cmp(32'(src_ack), exp_vec.size() ? 32'h1 << (exp_vec[0] - 16'h1) : 'x);
			exp_push.push_back(8'(pc_now - 16'h1));
			exp_push.push_back(8'((pc_now - 16'h1) >> 8));
		end
		if (presetn && push_we === 1'b1) begin
			ep = (exp_push.size() != 0) ? exp_push.pop_front() : 'x;
			cmp(32'(push_data), 32'(ep));
		end
		if (presetn && vector_valid === 1'b1) begin
			ev = (exp_vec.size() != 0) ? exp_vec.pop_front() : 16'hxxxx;
			cmp(32'(vector_addr), 32'(ev));
		end
		if (presetn && alu_valid === 1'b1) begin
			ea = (exp_alu.size() != 0) ? exp_alu.pop_front() : 'x;
			cmp(32'({alu_wb_dst, alu_result}), 32'(ea));
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic [2:0] o;
		void'($urandom(32'hd9ca5f15));
		exp_vec.push_back(16'h0);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(CIV_OFF_SP_LOW, 32'(TOP[7:0]));
		rdc(CIV_OFF_SP_HIGH, 32'(TOP[15:8]));
		r = $urandom;
		apb(1'b1, CIV_OFF_SP_HIGH, 32'(r[7:0]));
		rdc(CIV_OFF_SP_HIGH, 32'(r[7:0]));
		apb(1'b1, CIV_OFF_SP_HIGH, 32'(TOP[15:8]));
		apb(1'b0, 8'h40, 32'h0);
		cmp(32'(er), 32'h1);
		rdc(CIV_OFF_INT_STATUS, 32'h4);
		src_req <= 8'h40;
		rdc(CIV_OFF_LEVEL, 32'h40);
		$display("test registers done");
		// level source 6 is gone before it is enabled and must never be served
		src(8'h68);
		rdc(CIV_OFF_FLAGS, 32'h28);
		apb(1'b1, CIV_OFF_ENABLE, 32'h6a);
		apb(1'b1, CIV_OFF_INT_MASK, 32'h1);
		exp_vec.push_back(16'h4);
		apb(1'b1, CIV_OFF_CONTROL, 32'h1);
		drain();
		rdc(CIV_OFF_FLAGS, 32'h20);
		apb(1'b0, CIV_OFF_CONTROL, 32'h0);
		cmp(32'(rd[0]), 32'h0);
		rdc(CIV_OFF_SP_LOW, 32'(TOP[7:0] - 8'h2));
		rdc(CIV_OFF_LAST_VECTOR, 32'h4);
		cmp(32'(irq), 32'h1);
		apb(1'b1, CIV_OFF_INT_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		cmp(32'(irq), 32'h0);
		$display("test entry done");
		exp_vec.push_back(16'h6);
		ret_cmd <= 1'b1;
		@(posedge pclk);
		ret_cmd <= 1'b0;
		drain();
		rdc(CIV_OFF_FLAGS, 32'h0);
		$display("test return done");
		src(8'h82);
		apb(1'b1, CIV_OFF_FLAGS, 32'h0);
		rdc(CIV_OFF_FLAGS, 32'h82);
		apb(1'b1, CIV_OFF_FLAGS, 32'h80);
		rdc(CIV_OFF_FLAGS, 32'h02);
		exp_vec.push_back(16'h2);
		apb(1'b1, CIV_OFF_CONTROL, 32'h1);
		drain();
		$display("test nesting done");
		for (int i = 0; i < 24; i++) begin
			@(posedge pclk);
			r = $urandom;
			o = r[26:24];
			alu_go <= 1'b1;
			alu_op <= o;
			alu_a <= r[7:0];
			alu_b <= r[15:8];
			alu_dst <= r[20:16];
			exp_alu.push_back({r[20:16], ref_alu(o, r[7:0], r[15:8])});
		end
		@(posedge pclk);
		alu_go <= 1'b0;
		drain();
		$display("test alu done");
		cmp(32'(exp_vec.size() + exp_alu.size() + exp_push.size()), 32'h0);
		final_report();
	end
endmodule

bind civ_top civ_chk #(.NSRC(NSRC)) i_chk (.pclk(pclk), .presetn(presetn),
	.src_ack(src_ack), .return_from_handler(return_from_handler),
	.vector_valid(vector_valid), .vector_addr(vector_addr), .push_we(push_we),
	.push_addr(push_addr), .alu_go(alu_go), .alu_op(alu_op), .alu_dst(alu_dst),
	.alu_a(alu_a), .alu_b(alu_b), .alu_valid(alu_valid), .alu_wb_dst(alu_wb_dst),
	.alu_result(alu_result));
